/* File: rtl/cbm_pkg.sv */
// Constants for the cartridge bank address mapper
package cbm_pkg;
  localparam int CBM_AW = 20;
  localparam logic [19:0] CBM_SPACE_LAST = 20'hfffff;
  localparam logic [19:0] CBM_RAM_BASE = 20'h00000;
  localparam logic [19:0] CBM_RAM_LAST = 20'h0ffff;
  localparam logic [19:0] CBM_UNUSED_BASE = 20'h10000;
  localparam logic [19:0] CBM_UNUSED_LAST = 20'h5ffff;
  localparam logic [19:0] CBM_RECOG_BASE = 20'h60000;
  localparam logic [19:0] CBM_RECOG_LAST = 20'h7ffff;
  localparam logic [19:0] CBM_CGEN_BASE = 20'h80000;
  localparam logic [19:0] CBM_CGEN_LAST = 20'hbffff;
  localparam logic [19:0] CBM_KERNEL_BASE = 20'hc0000;
  localparam logic [19:0] CBM_WIN_A_BASE = 20'h40000;
  localparam logic [19:0] CBM_WIN_A_LAST = 20'h7ffff;
  localparam logic [19:0] CBM_WIN_B_BASE = 20'h80000;
  localparam logic [19:0] CBM_WIN_B_LAST = 20'hbffff;
  localparam logic [19:0] CBM_HEADER_ADDR = 20'h40000;
  // Bit positions
  localparam int CBM_TOP_BIT = 19;
  localparam int CBM_PASS_MSB = 17;
  localparam int CBM_QUARTER_LSB = 18;
  // Bank labels of the four cartridge quarters, ascending address
  localparam logic [1:0] CBM_BANK_Q0 = 2'h2;
  localparam logic [1:0] CBM_BANK_Q1 = 2'h0;
  localparam logic [1:0] CBM_BANK_Q2 = 2'h1;
  localparam logic [1:0] CBM_BANK_Q3 = 2'h3;
  // Reset values
  localparam logic CBM_CS_IDLE = 1'b1;
  localparam logic CBM_SYNC_RST = 1'b0;
endpackage

/* File: rtl/cbm_sync2.sv */
// Two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module cbm_sync2
  import cbm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic d,
  output logic q
);
  logic meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= CBM_SYNC_RST;
      q <= CBM_SYNC_RST;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/cbm_mapper.sv */
// Real Mode address decoder for the cartridge slot and on-board memories
`timescale 1ns/1ps
`default_nettype none
module cbm_mapper
  import cbm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [19:0] cpu_addr,
  input wire logic cpu_access,
  input wire logic bank_select_port_bit,
  input wire logic cart_target_sel,
  output logic ram_cs_n,
  output logic recog_cs_n,
  output logic cgen_cs_n,
  output logic kernel_cs_n,
  output logic cartridge_chip_select_n,
  output logic cartridge_top_address_line,
  output logic [18:0] cart_addr,
  output logic [1:0] cart_bank,
  output logic header_hit
);
  // Synchronised copies of the two asynchronous controls
  logic bank_sel_s;
  logic cart_tgt_s;
  // Region hits for the current processor address
  logic in_ram;
  logic in_unused;
  logic in_recog;
  logic in_cgen;
  logic in_kernel;
  logic in_cart_win;
  // Qualified requests, one per target
  logic board_go;
  logic ram_req;
  logic recog_req;
  logic cgen_req;
  logic kernel_req;
  logic cart_go;
  // Remapped cartridge address
  logic [19:0] cart_phys;

  // Range test used by every region
  function automatic logic cbm_in(input logic [19:0] a, input logic [19:0] lo,
                                  input logic [19:0] hi);
    cbm_in = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [1:0] cbm_bank_of(input logic [1:0] q);
    unique case (q)
      2'h0: cbm_bank_of = CBM_BANK_Q0;
      2'h1: cbm_bank_of = CBM_BANK_Q1;
      2'h2: cbm_bank_of = CBM_BANK_Q2;
      2'h3: cbm_bank_of = CBM_BANK_Q3;
    endcase
  endfunction

  // Active-low strobe from a request; one place so every select agrees
  function automatic logic cbm_sel_n(input logic req);
    cbm_sel_n = !req;
  endfunction

  // Port bit comes from an outside pin, so it is synchronised
  cbm_sync2 u_sync_bank (
    .clk(clk),
    .nrst(nrst),
    .d(bank_select_port_bit),
    .q(bank_sel_s)
  );

  // Cartridge target control also arrives asynchronously
  cbm_sync2 u_sync_tgt (
    .clk(clk),
    .nrst(nrst),
    .d(cart_target_sel),
    .q(cart_tgt_s)
  );

  // full 20-bit space, no address beyond it
  always_comb begin
    in_ram = cbm_in(cpu_addr, CBM_RAM_BASE, CBM_RAM_LAST);
    in_unused = cbm_in(cpu_addr, CBM_UNUSED_BASE, CBM_UNUSED_LAST);
    in_recog = cbm_in(cpu_addr, CBM_RECOG_BASE, CBM_RECOG_LAST);
    in_cgen = cbm_in(cpu_addr, CBM_CGEN_BASE, CBM_CGEN_LAST);
    in_kernel = cbm_in(cpu_addr, CBM_KERNEL_BASE, CBM_SPACE_LAST);
    in_cart_win = cbm_in(cpu_addr, CBM_WIN_A_BASE, CBM_WIN_B_LAST);
  end

  // hole stays dark to on-board selects
  // Redundant with the region map, but guards the hole against a stray decode edit
  assign board_go = cpu_access && !in_unused;

  // Per-target requests; the two shared windows yield to the cartridge
  always_comb begin
    ram_req = board_go && in_ram;
    recog_req = board_go && in_recog && !cart_tgt_s;
    cgen_req = board_go && in_cgen && !cart_tgt_s;
    kernel_req = board_go && in_kernel;
  end

  // target selection steers the shared windows
  // Target and bank bits are synchronised, so a switch shows two cycles late
  assign cart_go = cpu_access && in_cart_win && cart_tgt_s;

  // select level replaces the top address bit
  // window A quarter bit 18 stays 1
  // window B quarter bit 18 stays 0
  assign cart_phys = {bank_sel_s, cpu_addr[CBM_QUARTER_LSB:0]};

  // Registered RAM select, one cycle after the access is taken
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ram_cs_n <= CBM_CS_IDLE;
    end else begin
      ram_cs_n <= cbm_sel_n(ram_req);
    end
  end

  // Registered recognition ROM select
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      recog_cs_n <= CBM_CS_IDLE;
    end else begin
      recog_cs_n <= cbm_sel_n(recog_req);
    end
  end

  // Registered character ROM select
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cgen_cs_n <= CBM_CS_IDLE;
    end else begin
      cgen_cs_n <= cbm_sel_n(cgen_req);
    end
  end

  // Registered kernel select; ignores target and bank so boot always works
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      kernel_cs_n <= CBM_CS_IDLE;
    end else begin
      kernel_cs_n <= cbm_sel_n(kernel_req);
    end
  end

  // cartridge select
  // One cycle per access cycle; released on the clock edge after access drops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cartridge_chip_select_n <= CBM_CS_IDLE;
    end else begin
      cartridge_chip_select_n <= cbm_sel_n(cart_go);
    end
  end

  // cartridge top line
  // Held between accesses so the cartridge never sees a stray bank flip
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cartridge_top_address_line <= 1'b0;
    end else if (cart_go) begin
      cartridge_top_address_line <= cart_phys[CBM_TOP_BIT];
    end
  end

  // low bits held
  // Kept from the last cartridge access to avoid address glitches
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cart_addr <= 19'h00000;
    end else if (cart_go) begin
      cart_addr <= cart_phys[18:0];
    end
  end

  // bank label
  // Follows the quarter that the last cartridge access reached
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cart_bank <= CBM_BANK_Q0;
    end else if (cart_go) begin
      cart_bank <= cbm_bank_of(cart_phys[CBM_TOP_BIT:CBM_QUARTER_LSB]);
    end
  end

  // header at processor address
  // Only the low bank puts cartridge 40000H behind processor 40000H
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      header_hit <= 1'b0;
    end else begin
      header_hit <= cart_go && (cpu_addr == CBM_HEADER_ADDR) && !bank_sel_s;
    end
  end
endmodule
`default_nettype wire

/* File: tb/cbm_mapper_monitor.sv */
// Checker on the mapper's ports
`timescale 1ns/1ps
`default_nettype none
module cbm_mapper_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [19:0] cpu_addr,
  input wire logic cpu_access,
  input wire logic bank_select_port_bit,
  input wire logic ram_cs_n,
  input wire logic recog_cs_n,
  input wire logic cgen_cs_n,
  input wire logic kernel_cs_n,
  input wire logic cartridge_chip_select_n,
  input wire logic cartridge_top_address_line,
  input wire logic [18:0] cart_addr,
  input wire logic [1:0] cart_bank,
  input wire logic header_hit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire [4:0] cs_n = {ram_cs_n, recog_cs_n, cgen_cs_n, kernel_cs_n, cartridge_chip_select_n};
  sequence acc_in(lo, hi);
    cpu_access && cpu_addr >= lo && cpu_addr <= hi;
  endsequence
  // Select timing, one-hot selects, address pass-through and labels
  ram_sel_a: assert property (acc_in(20'h00000, 20'h0ffff) |=> cs_n == 5'h0f)
    else $error("ram select wrong");
  unused_none_a: assert property (acc_in(20'h10000, 20'h3ffff) |=> cs_n == 5'h1f)
    else $error("unused region selected");
  kernel_sel_a: assert property (acc_in(20'hc0000, 20'hfffff) |=> cs_n == 5'h1d)
    else $error("kernel select wrong");
  cs_idle_a: assert property (!cpu_access |=> cs_n == 5'h1f)
    else $error("select without access");
  one_hot_a: assert property ($onehot0(~cs_n))
    else $error("two selects low");
  pass_bits_a: assert property (!cartridge_chip_select_n |->
    cart_addr == $past(cpu_addr[18:0])) else $error("cartridge address bits altered");
  top_line_a: assert property (!cartridge_chip_select_n |->
    cartridge_top_address_line == $past(bank_select_port_bit, 3)) else $error("top line wrong");
  bank_label_a: assert property (cart_bank == (cartridge_top_address_line ?
    (cart_addr[18] ? 2'h3 : 2'h1) : (cart_addr[18] ? 2'h0 : 2'h2))) else $error("bad bank label");
  header_sel_a: assert property (header_hit |-> !cartridge_chip_select_n &&
    cart_addr == 19'h40000 && !cartridge_top_address_line) else $error("header hit wrong");
endmodule
`default_nettype wire

/* File: tb/cbm_cart_model.sv */
// Behavioural cartridge ROM on the general bus
`timescale 1ns/1ps
`default_nettype none
module cbm_cart_model (
  input wire logic cs_n,
  input wire logic top,
  input wire logic [18:0] addr,
  output logic [7:0] data
);
  logic [7:0] last = 8'h00;
  // header reachable when selected
  // Deselected bus shows the inverse of the last byte, never a stale match
  always @(cs_n or top or addr) begin
    if (!cs_n) last = addr[7:0] ^ {top, addr[18], 6'h15};
    data = cs_n ? ~last : last;
  end
endmodule
`default_nettype wire

/* File: tb/cbm_mapper_tb.sv */
// Self-checking bench for the cartridge bank address mapper
`timescale 1ns/1ps
`default_nettype none
module cbm_mapper_tb;
  logic clk = 1'b0, nrst = 1'b0, cpu_access = 1'b0;
  logic bank_select_port_bit = 1'b0, cart_target_sel = 1'b0;
  logic [19:0] cpu_addr = 20'h00000;
  logic ram_cs_n, recog_cs_n, cgen_cs_n, kernel_cs_n, cartridge_chip_select_n;
  logic cartridge_top_address_line, header_hit;
  logic [18:0] cart_addr;
  logic [1:0] cart_bank;
  logic [7:0] data;
  wire [4:0] sel_n = {ram_cs_n, recog_cs_n, cgen_cs_n, kernel_cs_n, cartridge_chip_select_n};
  int err_total = 0, samples_checked = 0;
  cbm_mapper dut (
    .clk(clk),
    .nrst(nrst),
    .cpu_addr(cpu_addr),
    .cpu_access(cpu_access),
    .bank_select_port_bit(bank_select_port_bit),
    .cart_target_sel(cart_target_sel),
    .ram_cs_n(ram_cs_n),
    .recog_cs_n(recog_cs_n),
    .cgen_cs_n(cgen_cs_n),
    .kernel_cs_n(kernel_cs_n),
    .cartridge_chip_select_n(cartridge_chip_select_n),
    .cartridge_top_address_line(cartridge_top_address_line),
    .cart_addr(cart_addr),
    .cart_bank(cart_bank),
    .header_hit(header_hit)
  );
  cbm_cart_model cart (.cs_n(cartridge_chip_select_n), .top(cartridge_top_address_line),
    .addr(cart_addr), .data(data));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Launch off the falling edge; the answer stands by the next one
  task automatic acc(input logic [19:0] a);
    cpu_addr = a;
    cpu_access = 1'b1;
    @(negedge clk);
  endtask
  // Back-to-back on-board decode at region boundaries, cartridge not owner
  task automatic t_board;
    logic [19:0] a [6] = '{20'h0ffff, 20'h10000, 20'h5ffff, 20'h60000, 20'hbffff, 20'hc0000};
    logic [4:0] e [6] = '{5'h0f, 5'h1f, 5'h1f, 5'h17, 5'h1b, 5'h1d};
    foreach (a[i]) begin
      acc(a[i]);
      chk(sel_n, e[i]);
    end
    cpu_access = 1'b0;
  endtask
  // Both bank levels through both windows, then hold after a kernel access
  task automatic t_cart;
    logic [19:0] a;
    logic [19:0] p;
    logic [19:0] ph [4] = '{20'h40000, 20'h3ffff, 20'hc0000, 20'hbffff};
    logic [1:0] lb [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    cart_target_sel = 1'b1;
    for (int b = 0; b < 2; b++) begin
      cpu_access = 1'b0;
      bank_select_port_bit = b[0];
      repeat (3) @(negedge clk);
      for (int w = 0; w < 2; w++) begin
        a = w[0] ? 20'hbffff : 20'h40000;
        p = ph[2 * b + w];
        acc(a);
        chk({cartridge_top_address_line, cart_addr}, p);
        chk(cart_bank, lb[2 * b + w]);
        chk(sel_n, 5'h1e);
        chk(header_hit, !b[0] && !w[0]);
        chk(data, p[7:0] ^ {p[19:18], 6'h15});
      end
    end
    acc(20'hc0000);
    chk(sel_n, 5'h1d);
    cpu_access = 1'b0;
    @(negedge clk);
    chk({cartridge_chip_select_n, cart_addr}, {1'b1, 19'h3ffff});
  endtask
  // Reset in mid-run, then the first cartridge access once the syncs settle
  task automatic t_reset;
    nrst = 1'b0;
    @(negedge clk);
    chk({sel_n, cartridge_top_address_line, cart_addr}, {5'h1f, 1'b0, 19'h00000});
    chk({cart_bank, header_hit}, {2'h2, 1'b0});
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    acc(20'h80000);
    cpu_access = 1'b0;
    chk({cartridge_top_address_line, cart_addr}, 20'h80000);
    chk(cart_bank, 2'h1);
  endtask
  initial forever #2.5 clk = ~clk;
  initial begin
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    t_board;
    t_cart;
    t_reset;
    tally_and_finish;
  end
  // Watchdog cuts a hang short
  initial begin
    repeat (500) @(posedge clk);
    err_total++;
    tally_and_finish;
  end
endmodule
bind cbm_mapper cbm_mapper_monitor mon (
  .clk(clk),
  .nrst(nrst),
  .cpu_addr(cpu_addr),
  .cpu_access(cpu_access),
  .bank_select_port_bit(bank_select_port_bit),
  .ram_cs_n(ram_cs_n),
  .recog_cs_n(recog_cs_n),
  .cgen_cs_n(cgen_cs_n),
  .kernel_cs_n(kernel_cs_n),
  .cartridge_chip_select_n(cartridge_chip_select_n),
  .cartridge_top_address_line(cartridge_top_address_line),
  .cart_addr(cart_addr),
  .cart_bank(cart_bank),
  .header_hit(header_hit)
);
`default_nettype wire
